// file: power_sleep_pkg.sv
package power_sleep_pkg;

    // register map, byte addresses on the bus
    localparam logic [7:0] PCR_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;

    // power control register fields
    localparam int unsigned IDLE_BIT = 0;
    localparam int unsigned SLEEP_BIT = 1;
    localparam int unsigned UF0_BIT = 2;
    localparam int unsigned UF1_BIT = 3;
    localparam int unsigned POF_BIT = 4;
    localparam int unsigned PCR_W = 5;
    localparam logic [4:0] PCR_RST = 5'h10;

    // status register fields
    localparam int unsigned ST_IDLE_BIT = 0;
    localparam int unsigned ST_SLEEP_BIT = 1;
    localparam int unsigned ST_OSC_BIT = 2;
    localparam int unsigned ST_SUPPLY_BIT = 3;
    localparam int unsigned ST_WAKE_BIT = 4;

    // delays in clk_i clock periods
    localparam int unsigned CNT_W = 11;
    localparam int unsigned RST_DELAY_CLKS = 1024;
    localparam int unsigned KBD_WAKE_CLKS = 1024;
    localparam logic [10:0] RST_LAST = 11'(RST_DELAY_CLKS - 1);
    localparam logic [10:0] KBD_LAST = 11'(KBD_WAKE_CLKS - 1);

    typedef enum logic [2:0] {
        ST_RESET,
        ST_RUN,
        ST_IDLE,
        ST_PDOWN,
        ST_PD_WAKE,
        ST_KBD_WAIT
    } mode_t;

endpackage

// file: power_sleep_ctrl.sv
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps

module power_sleep_ctrl
    import power_sleep_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic supply_monitor_ok_i,
    input wire logic oscillator_input_i,
    input wire logic reset_pin_i,
    input wire logic external_irq_zero_n_i,
    input wire logic external_irq_one_n_i,
    input wire logic irq_zero_en_i,
    input wire logic irq_one_en_i,
    input wire logic kbd_irq_i,
    input wire logic kbd_en_i,
    input wire logic usb_irq_i,
    input wire logic usb_en_i,
    input wire logic irq_pending_i,
    input wire logic ext_prog_mem_i,
    input wire logic core_ale_i,
    input wire logic core_fetch_strobe_i,
    input wire logic [7:0] core_port0_i,
    input wire logic [7:0] core_port0_oe_i,
    input wire logic [7:0] core_port2_i,
    input wire logic [7:0] core_addr_hi_i,
    output logic int_rst_o,
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o,
    output logic osc_run_o,
    output logic ale_o,
    output logic program_fetch_strobe_o,
    output logic [7:0] port0_o,
    output logic [7:0] port0_oe_o,
    output logic [7:0] port2_o
);

    ////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        mode_t mode;
        logic [10:0] cnt;
        logic rst;
        logic sup1;
        logic sup2;
        logic osc1;
        logic osc2;
        logic pin1;
        logic pin2;
        logic ia1;
        logic ia2;
        logic ib1;
        logic ib2;
        logic seen_hi;
        logic seen_lo;
        logic lo0;
        logic lo1;
        logic woke;
        logic [4:0] pcr;
        logic [7:0] p0_hold;
        logic [7:0] p2_hold;
        logic ack;
        logic [31:0] dat;
        logic cpu_en;
        logic per_en;
        logic osc_run;
        logic ale;
        logic program_fetch_strobe;
        logic [7:0] p0;
        logic [7:0] p0_oe;
        logic [7:0] p2;
    } state_t;

    localparam state_t RST_STATE = '{
        mode: ST_RESET,
        rst: 1'b1,
        pcr: PCR_RST,
        per_en: 1'b1,
        osc_run: 1'b1,
        default: '0
    };

    state_t q;
    state_t n;
    logic req;
    logic wake0;
    logic wake1;
    logic held;

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        n = q;
        // two-stage synchronisers for pins
        n.sup1 = supply_monitor_ok_i;
        n.sup2 = q.sup1;
        n.osc1 = oscillator_input_i;
        n.osc2 = q.osc1;
        n.pin1 = reset_pin_i;
        n.pin2 = q.pin1;
        n.ia1 = external_irq_zero_n_i;
        n.ia2 = q.ia1;
        n.ib1 = external_irq_one_n_i;
        n.ib2 = q.ib1;

        // bus slave: ack one cycle after request, write lands at ack edge
        req = wb_cyc_i & wb_stb_i;
        n.ack = req & ~q.ack;
        if (req && !q.ack) begin
            n.dat = '0;
            if (wb_adr_i == PCR_OFS) begin
                n.dat[PCR_W-1:0] = q.pcr;
            end else if (wb_adr_i == STAT_OFS) begin
                n.dat[ST_IDLE_BIT] = (q.mode == ST_IDLE);
                n.dat[ST_SLEEP_BIT] = (q.mode == ST_PDOWN) |
                    (q.mode == ST_PD_WAKE) | (q.mode == ST_KBD_WAIT);
                n.dat[ST_OSC_BIT] = q.osc_run;
                n.dat[ST_SUPPLY_BIT] = q.sup2;
                n.dat[ST_WAKE_BIT] = q.woke;
            end
        end
        // flags plain software bits, register write
        if (req && q.ack && wb_we_i && wb_sel_i[0] && !q.rst &&
            wb_adr_i == PCR_OFS) begin
            n.pcr = wb_dat_i[PCR_W-1:0];
        end

        wake0 = irq_zero_en_i & ~q.ia2;
        wake1 = irq_one_en_i & ~q.ib2;

        unique case (q.mode)
            ST_RESET: begin
                n.seen_hi = q.seen_hi | q.osc2;
                n.seen_lo = q.seen_lo | ~q.osc2;
                if (q.seen_hi && q.seen_lo) begin
                    if (q.cnt == RST_LAST) begin
                        // clocked release: all logic leaves reset together
                        n.rst = 1'b0;
                        n.mode = ST_RUN;
                        n.cnt = '0;
                    end else begin
                        n.cnt = q.cnt + 11'h001;
                    end
                end
            end
            ST_RUN: begin
                n.woke = 1'b0;
                if (q.pcr[SLEEP_BIT]) begin
                    n.mode = ST_PDOWN;
                    n.p0_hold = core_port0_i;
                    n.p2_hold = core_port2_i;
                end else if (q.pcr[IDLE_BIT]) begin
                    n.mode = ST_IDLE;
                    n.p0_hold = core_port0_i;
                    n.p2_hold = core_port2_i;
                end
            end
            ST_IDLE: begin
                if (irq_pending_i) begin
                    n.pcr[IDLE_BIT] = 1'b0;
                    n.mode = ST_RUN;
                end
            end
            ST_PDOWN: begin
                // only these sources, besides supply loss or the reset pin, end power-down
                if (wake0 || wake1) begin
                    n.mode = ST_PD_WAKE;
                    n.lo0 = wake0;
                    n.lo1 = wake1;
                end else if (kbd_en_i && kbd_irq_i) begin
                    n.mode = ST_KBD_WAIT;
                    n.cnt = '0;
                end else if (usb_en_i && usb_irq_i) begin
                    n.mode = ST_RUN;
                    n.pcr[IDLE_BIT] = 1'b0;
                    n.pcr[SLEEP_BIT] = 1'b0;
                    n.woke = 1'b1;
                end
            end
            ST_PD_WAKE: begin
                n.lo0 = q.lo0 | wake0;
                n.lo1 = q.lo1 | wake1;
                // first released input completes the exit
                if ((q.lo0 && q.ia2) || (q.lo1 && q.ib2)) begin
                    n.mode = ST_RUN;
                    n.pcr[IDLE_BIT] = 1'b0;
                    n.pcr[SLEEP_BIT] = 1'b0;
                    n.lo0 = 1'b0;
                    n.lo1 = 1'b0;
                    n.woke = 1'b1;
                end
            end
            ST_KBD_WAIT: begin
                if (q.cnt == KBD_LAST) begin
                    n.mode = ST_RUN;
                    n.cnt = '0;
                    n.pcr[IDLE_BIT] = 1'b0;
                    n.pcr[SLEEP_BIT] = 1'b0;
                    n.woke = 1'b1;
                end else begin
                    n.cnt = q.cnt + 11'h001;
                end
            end
        endcase

        // supply loss or reset pin override everything at once and restart the delay count
        if (!q.sup2 || q.pin2) begin
            n.mode = ST_RESET;
            n.rst = 1'b1;
            n.cnt = '0;
            n.seen_hi = 1'b0;
            n.seen_lo = 1'b0;
            n.lo0 = 1'b0;
            n.lo1 = 1'b0;
            n.woke = 1'b0;
        end
        if (n.rst) begin
            // power-off flag survives; power application or a software write sets it
            n.pcr[SLEEP_BIT] = 1'b0;
            n.pcr[IDLE_BIT] = 1'b0;
            n.pcr[UF0_BIT] = 1'b0;
            n.pcr[UF1_BIT] = 1'b0;
        end

        // pin and clock outputs follow the next mode so they flop in step
        held = (n.mode != ST_RUN) && (n.mode != ST_RESET);
        n.cpu_en = (n.mode == ST_RUN) && !n.rst;
        n.per_en = (n.mode == ST_RUN) || (n.mode == ST_IDLE) ||
            (n.mode == ST_RESET);
        n.osc_run = (n.mode != ST_PDOWN);
        if (n.mode == ST_IDLE) begin
            n.ale = 1'b1;
            n.program_fetch_strobe = 1'b1;
        end else if (held) begin
            n.ale = 1'b0;
            n.program_fetch_strobe = 1'b0;
        end else begin
            n.ale = core_ale_i;
            n.program_fetch_strobe = core_fetch_strobe_i;
        end
        if (!held) begin
            n.p0 = core_port0_i;
            n.p0_oe = core_port0_oe_i;
            n.p2 = core_port2_i;
        end else if (ext_prog_mem_i) begin
            n.p0 = '0;
            n.p0_oe = '0;
            n.p2 = (n.mode == ST_IDLE) ? core_addr_hi_i : n.p2_hold;
        end else begin
            // open-drain style hold: a one must not fight the bus
            n.p0 = '0;
            n.p0_oe = ~n.p0_hold;
            n.p2 = n.p2_hold;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q <= RST_STATE;
        end else begin
            q <= n;
        end
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;
    assign int_rst_o = q.rst;
    assign cpu_clk_en_o = q.cpu_en;
    assign periph_clk_en_o = q.per_en;
    assign osc_run_o = q.osc_run;
    assign ale_o = q.ale;
    assign program_fetch_strobe_o = q.program_fetch_strobe;
    assign port0_o = q.p0;
    assign port0_oe_o = q.p0_oe;
    assign port2_o = q.p2;

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_count_done;
        q.mode == ST_RESET && q.seen_hi && q.seen_lo && q.cnt == RST_LAST;
    endsequence

    sequence s_pd_exit;
        $past(q.mode) != ST_RUN && $past(q.mode) != ST_IDLE &&
            $past(q.mode) != ST_RESET && q.mode == ST_RUN;
    endsequence

    property p_supply_loss;
        !q.sup2 |=> int_rst_o && !cpu_clk_en_o;
    endproperty
    a_supply_loss: assert property (p_supply_loss)
        else $error("reset not raised after supply loss");

    property p_release_count;
        $fell(int_rst_o) |-> $past(q.cnt) == RST_LAST && cpu_clk_en_o;
    endproperty
    a_release_count: assert property (p_release_count)
        else $error("reset released before full delay count");

    property p_count_release;
        s_count_done and (q.sup2 && !q.pin2) |=> !int_rst_o;
    endproperty
    a_count_release: assert property (p_count_release)
        else $error("reset not released on count end");

    property p_idle_entry;
        q.mode == ST_RUN && !q.rst && q.pcr[IDLE_BIT] &&
            !q.pcr[SLEEP_BIT] && q.sup2 && !q.pin2
            |=> q.mode == ST_IDLE && !cpu_clk_en_o && periph_clk_en_o;
    endproperty
    a_idle_entry: assert property (p_idle_entry)
        else $error("idle not entered with gated cpu clock");

    property p_idle_strobes;
        q.mode == ST_IDLE |-> ale_o && program_fetch_strobe_o;
    endproperty
    a_idle_strobes: assert property (p_idle_strobes)
        else $error("strobes not high in idle");

    property p_idle_wake;
        q.mode == ST_IDLE && irq_pending_i && q.sup2 && !q.pin2
            |=> q.mode == ST_RUN && !q.pcr[IDLE_BIT];
    endproperty
    a_idle_wake: assert property (p_idle_wake)
        else $error("interrupt did not end idle");

    property p_pd_strobes;
        q.mode == ST_PDOWN |-> !ale_o && !program_fetch_strobe_o &&
            !osc_run_o;
    endproperty
    a_pd_strobes: assert property (p_pd_strobes)
        else $error("power-down pin state wrong");

    property p_port0_zero;
        q.mode == ST_IDLE || q.mode == ST_PDOWN |-> (port0_o & port0_oe_o)
            == 8'h00;
    endproperty
    a_port0_zero: assert property (p_port0_zero)
        else $error("port 0 drives a one while held");

    property p_kbd_wait;
        $past(q.mode) == ST_KBD_WAIT && q.mode == ST_RUN |->
            $past(q.cnt) == KBD_LAST;
    endproperty
    a_kbd_wait: assert property (p_kbd_wait)
        else $error("keyboard wake shorter than 1024 clocks");

    property p_exit_clears;
        s_pd_exit |-> !q.pcr[IDLE_BIT] && !q.pcr[SLEEP_BIT];
    endproperty
    a_exit_clears: assert property (p_exit_clears)
        else $error("request bits left set after power-down exit");

    property p_reset_clears;
        int_rst_o |-> !q.pcr[SLEEP_BIT];
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("sleep request survives reset");

    property p_pd_only_sources;
        q.mode == ST_PDOWN && q.sup2 && !q.pin2 && !(kbd_en_i && kbd_irq_i)
            && !(usb_en_i && usb_irq_i) && !wake0 && !wake1
            |=> q.mode == ST_PDOWN;
    endproperty
    a_pd_only_sources: assert property (p_pd_only_sources)
        else $error("power-down left without a waking source");

endmodule

// file: core_side_model.sv
`timescale 1ns/1ps

// stands in for the crystal and the cpu core beside the sequencer
module core_side_model (
    input wire logic clk_i,
    input wire logic osc_run_i,
    input wire logic [7:0] pat_i,
    output logic oscillator_input_o,
    output logic core_ale_o,
    output logic core_fetch_strobe_o,
    output logic [7:0] core_port0_o,
    output logic [7:0] core_port0_oe_o,
    output logic [7:0] core_port2_o,
    output logic [7:0] core_addr_hi_o
);
    logic [3:0] div_q;

    initial begin
        div_q = 4'h0;
        oscillator_input_o = 1'b0;
    end

    // a stopped crystal makes no edges, so qualification cannot cheat
    always @(posedge clk_i) begin
        if (osc_run_i) begin
            div_q <= div_q + 4'h1;
            oscillator_input_o <= div_q[1];
        end
    end

    // strobes toggle while running so a held level is visible
    assign core_ale_o = div_q[0];
    assign core_fetch_strobe_o = ~div_q[0];
    assign core_port0_o = pat_i;
    assign core_port0_oe_o = 8'hFF;
    assign core_port2_o = ~pat_i;
    assign core_addr_hi_o = pat_i ^ 8'h5A;
endmodule

// file: power_sleep_ctrl_bench.sv
`timescale 1ns/1ps

module power_sleep_ctrl_bench;
    import power_sleep_pkg::*;
    logic clk_i, sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i, pat, held;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic supply_monitor_ok_i, oscillator_input_i, reset_pin_i;
    logic external_irq_zero_n_i, external_irq_one_n_i, irq_zero_en_i;
    logic irq_one_en_i, kbd_irq_i, kbd_en_i, usb_irq_i, usb_en_i;
    logic irq_pending_i, ext_prog_mem_i, core_ale_i, core_fetch_strobe_i;
    logic [7:0] core_port0_i, core_port0_oe_i, core_port2_i, core_addr_hi_i;
    logic int_rst_o, cpu_clk_en_o, periph_clk_en_o, osc_run_o, ale_o;
    logic program_fetch_strobe_o;
    logic [7:0] port0_o, port0_oe_o, port2_o;
    int n_fail, n_compared, exp_pcr, k;

    power_sleep_ctrl power_sleep_ctrl_inst (.clk_i, .sys_rst_i, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .supply_monitor_ok_i, .oscillator_input_i, .reset_pin_i,
        .external_irq_zero_n_i, .external_irq_one_n_i, .irq_zero_en_i,
        .irq_one_en_i, .kbd_irq_i, .kbd_en_i, .usb_irq_i, .usb_en_i,
        .irq_pending_i, .ext_prog_mem_i, .core_ale_i, .core_fetch_strobe_i,
        .core_port0_i, .core_port0_oe_i, .core_port2_i, .core_addr_hi_i,
        .int_rst_o, .cpu_clk_en_o, .periph_clk_en_o, .osc_run_o, .ale_o,
        .program_fetch_strobe_o, .port0_o, .port0_oe_o, .port2_o);

    core_side_model core_side_model_inst (.clk_i, .osc_run_i(osc_run_o),
        .pat_i(pat), .oscillator_input_o(oscillator_input_i),
        .core_ale_o(core_ale_i), .core_fetch_strobe_o(core_fetch_strobe_i),
        .core_port0_o(core_port0_i), .core_port0_oe_o(core_port0_oe_i),
        .core_port2_o(core_port2_i), .core_addr_hi_o(core_addr_hi_i));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    initial begin
        #100000;
        n_fail++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // the slave picks its own latency; only the bound stops a hang
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        if (n >= 100) n_fail++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(q, e);
    endtask

    task automatic wait_rel;
        k = 0;
        while (int_rst_o === 1'b1 && k < 3000) begin
            tick(1);
            k++;
        end
        check(32'(k >= RST_DELAY_CLKS - 2 && k <= RST_DELAY_CLKS + 24), 1);
    endtask

    task automatic wait_run(input int lo, input int hi);
        k = 0;
        while (cpu_clk_en_o !== 1'b1 && k < 2000) begin
            tick(1);
            k++;
        end
        check(32'(k >= lo && k <= hi), 1);
    endtask

    task automatic src(input int j, input logic on);
        @(posedge clk_i);
        case (j)
            0: external_irq_zero_n_i <= ~on;
            1: external_irq_one_n_i <= ~on;
            2: kbd_irq_i <= on;
            default: usb_irq_i <= on;
        endcase
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {sys_rst_i, supply_monitor_ok_i} = 2'b11;
        {wb_cyc_i, wb_stb_i, wb_we_i, reset_pin_i, kbd_irq_i} = 5'h00;
        {external_irq_zero_n_i, external_irq_one_n_i} = 2'b11;
        {irq_zero_en_i, irq_one_en_i, kbd_en_i, usb_en_i} = 4'h0;
        {usb_irq_i, irq_pending_i, ext_prog_mem_i} = 3'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        pat = 8'h00;
        n_fail = 0;
        n_compared = 0;
        k = $urandom(32'h5BFF7FAD);
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        tick(1);
        check(int_rst_o, 1'b1);
        wait_rel();
        rd(PCR_OFS, 32'h10);
        rd(8'h08, 32'h0);
        // idle with internal then external program memory
        for (int m = 0; m < 2; m++) begin
            @(posedge clk_i);
            ext_prog_mem_i <= m[0];
            pat <= 8'($urandom);
            exp_pcr = 32'h11 | (m ? 32'h8 : 32'h4);
            bus(1'b1, PCR_OFS, exp_pcr);
            held = pat;
            tick(1);
            check({cpu_clk_en_o, periph_clk_en_o}, 2'b01);
            check({ale_o, program_fetch_strobe_o}, 2'b11);
            @(posedge clk_i);
            pat <= ~held;
            tick(2);
            if (m == 0) check({port0_o, port0_oe_o, port2_o}, {8'h0, ~held, ~held});
            else check({port0_oe_o, port2_o}, {8'h0, ~held ^ 8'h5A});
            rd(PCR_OFS, exp_pcr);
            @(posedge clk_i);
            irq_pending_i <= 1'b1;
            tick(1);
            check(cpu_clk_en_o, 1'b1);
            @(posedge clk_i);
            irq_pending_i <= 1'b0;
            exp_pcr = exp_pcr & 32'h1E;
            rd(PCR_OFS, exp_pcr);
        end
        // power-down with both request bits, one wake source enabled
        for (int j = 0; j < 4; j++) begin
            @(posedge clk_i);
            {irq_zero_en_i, irq_one_en_i, kbd_en_i, usb_en_i} <= 4'h8 >> j;
            ext_prog_mem_i <= 1'b0;
            exp_pcr = 32'h13 | ($urandom & 32'hC);
            bus(1'b1, PCR_OFS, exp_pcr);
            tick(1);
            check({osc_run_o, cpu_clk_en_o, ale_o, program_fetch_strobe_o}, 4'h0);
            for (int i = 0; i < 4; i++) if (i != j) src(i, 1'b1);
            tick(8);
            check({osc_run_o, cpu_clk_en_o}, 2'b00);
            for (int i = 0; i < 4; i++) if (i != j) src(i, 1'b0);
            src(j, 1'b1);
            if (j < 2) begin
                tick(4);
                check({osc_run_o, cpu_clk_en_o}, 2'b10);
                src(j, 1'b0);
            end
            wait_run(j == 2 ? KBD_WAKE_CLKS : 1, j == 2 ? KBD_WAKE_CLKS + 8 : 8);
            if (j >= 2) src(j, 1'b0);
            exp_pcr = exp_pcr & 32'h1C;
            rd(PCR_OFS, exp_pcr);
        end
        // pin reset ends power-down; supply is kept good meanwhile
        bus(1'b1, PCR_OFS, 32'h12 | ($urandom & 32'hC));
        tick(1);
        check(osc_run_o, 1'b0);
        @(posedge clk_i);
        reset_pin_i <= 1'b1;
        tick(4);
        check(int_rst_o, 1'b1);
        repeat (20) @(posedge clk_i);
        reset_pin_i <= 1'b0;
        wait_rel();
        rd(PCR_OFS, 32'h10);
        repeat ($urandom_range(1, 50)) @(posedge clk_i);
        supply_monitor_ok_i <= 1'b0;
        tick(4);
        check(int_rst_o, 1'b1);
        @(posedge clk_i);
        supply_monitor_ok_i <= 1'b1;
        wait_rel();
        bus(1'b1, PCR_OFS, 32'h0);
        rd(PCR_OFS, 32'h0);
        bus(1'b1, PCR_OFS, 32'h10);
        rd(PCR_OFS, 32'h10);
        give_verdict();
    end
endmodule
